// ==== shared/spi_status_pkg.sv ====
/*
  Package for the serial status and data block: register offsets, bit
  positions, reset values, bus codes and serial timing counts.
  Assumes a 50 MHz core clock and 32-bit AXI4-Lite register access.
*/
// Operation
// RQ1 - transfer_done_flag is bit 7; set when a byte completes; interrupts if enabled
// RQ2 - transfer_done_flag clears by a status access then a data read or write
// RQ3 - while transfer_done_flag is set, data writes are ignored until status read
// RQ4 - write_collision_flag bit 6 sets on data write during a transfer
// RQ5 - overrun_flag bit 5 sets when a byte completes while done flag set
// RQ6 - overrun_flag clears when software reads the status register
// RQ7 - master_fault_flag bit 4 sets when select goes low in master mode
// RQ8 - master_fault_flag clears by status access while set, then control write
// RQ9 - data output driven only when output_disable bit 2 is 0 and enabled
// RQ10 - select_soft_manage bit 1 set makes the select come from software
// RQ11 - under software management select_soft_level 0 selects, 1 deselects
// RQ12 - as master, a data register write starts a new byte exchange unless a byte is moving or done is pending
// RQ13 - completed byte is copied to a receive buffer; data reads return it; the code keeps the old byte if one completes while done is set
// RQ14 - a data register write loads the transmit shift register directly
// RQ15 - software writes zero to reserved status bit 3
// RQ16 - one interrupt: done, overrun or fault flags, gated by irq enable
package spi_status_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_CTL_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA_IO = 8'h08;

  // control register fields
  localparam int CTL_IRQ_EN_BIT = 7;
  localparam int CTL_PERIPH_EN_BIT = 6;
  localparam int CTL_MASTER_BIT = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // status register fields
  localparam int ST_DONE_BIT = 7;
  localparam int ST_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int ST_OVR_BIT = 5;
  localparam int ST_MASTER_FAULT_FLAG_BIT = 4;
  localparam int ST_SOD_BIT = 2;
  localparam int ST_SSM_BIT = 1;
  localparam int ST_SSI_BIT = 0;
  localparam logic [2:0] SOFT_BITS_RESET = 3'h0;
  localparam logic [7:0] RX_BUF_RESET = 8'h00;

  // ************************************************************
  // bus answers
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // serial timing
  // ************************************************************
  localparam int CLK_MHZ = 50;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ) / 1000;
  localparam int BITS_PER_BYTE = 8;

endpackage

// ==== shared/spi_shift_if.sv ====
/*
  Interface between the register side and the shift engine.
  Assumes both ends run on the same core clock.
*/
interface spi_shift_if;
  logic load;
  logic [7:0] load_data;
  logic is_master;
  logic enabled;
  logic selected;
  logic sck_s;
  logic din_s;
  logic sdo;
  logic sck_out;
  logic busy;
  logic done;
  logic [7:0] rx_data;

  modport regs (
    output load, load_data, is_master, enabled, selected, sck_s, din_s,
    input sdo, sck_out, busy, done, rx_data
  );
  modport engine (
    input load, load_data, is_master, enabled, selected, sck_s, din_s,
    output sdo, sck_out, busy, done, rx_data
  );
endinterface

// ==== hdl/spi_sync2.sv ====
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes the inputs are asynchronous to the core clock.
*/
module spi_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==== hdl/spi_shift_engine.sv ====
/*
  Shift engine: one byte exchange, msb first, clock idle low, sample on
  the rising edge and shift on the falling edge. Master makes the clock;
  slave finds edges of the synchronised clock.
  Assumes sck_s and din_s are already synchronised.
*/
module spi_shift_engine (
  input wire logic clk,
  input wire logic rst_n,
  spi_shift_if.engine sif
);
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic [7:0] div_q;
  logic busy_q;
  logic sck_q;
  logic done_q;
  logic samp_q;
  logic sck_prev_q;
  logic rise;
  logic fall;
  logic tick;

  assign tick = (div_q == 8'(spi_status_pkg::SCK_HALF_CYC - 1));
  assign rise = sif.is_master ? (tick && !sck_q) : (sif.sck_s && !sck_prev_q);
  assign fall = sif.is_master ? (tick && sck_q) : (!sif.sck_s && sck_prev_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sif.sck_s;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !busy_q || !sif.is_master || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      sck_q <= 1'b0;
      done_q <= 1'b0;
      samp_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sif.load) begin
        sh_q <= sif.load_data; // [RQ14]
        cnt_q <= 4'h0;
        busy_q <= sif.is_master; // [RQ12]
        sck_q <= 1'b0;
      end else if (!sif.enabled || (!sif.is_master && !sif.selected)) begin
        cnt_q <= 4'h0;
        busy_q <= 1'b0;
        sck_q <= 1'b0;
      end else if (sif.is_master ? busy_q : 1'b1) begin
        if (sif.is_master && tick) begin
          sck_q <= !sck_q;
        end
        if (rise) begin
          samp_q <= sif.din_s;
          busy_q <= 1'b1;
          cnt_q <= cnt_q + 4'h1;
        end else if (fall && cnt_q != 4'h0) begin
          // shift on the falling edge; the clock ends low after the byte
          sh_q <= {sh_q[6:0], samp_q};
          if (cnt_q == 4'(spi_status_pkg::BITS_PER_BYTE)) begin
            done_q <= 1'b1; // [RQ1]
            cnt_q <= 4'h0;
            busy_q <= 1'b0;
          end
        end
      end
    end
  end

  assign sif.sdo = sh_q[7];
  assign sif.sck_out = sck_q;
  assign sif.busy = busy_q;
  assign sif.done = done_q;
  assign sif.rx_data = sh_q;
endmodule

// ==== hdl/spi_status_data.sv ====
/*
  Serial peripheral status and data block with an AXI4-Lite register
  slave, flag sequencing, select management and pin control.
  Assumes the pins are asynchronous and reach logic through two flops;
  the external party keeps its own signalling.
*/
module spi_status_data (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // axi write address
  input wire logic AXI_AWVALID_IN,
  output logic AXI_AWREADY_OUT,
  input wire logic [7:0] AXI_AWADDR_IN,
  // axi write data
  input wire logic AXI_WVALID_IN,
  output logic AXI_WREADY_OUT,
  input wire logic [31:0] AXI_WDATA_IN,
  input wire logic [3:0] AXI_WSTRB_IN,
  // axi write response
  output logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  output logic [1:0] AXI_BRESP_OUT,
  // axi read address
  input wire logic AXI_ARVALID_IN,
  output logic AXI_ARREADY_OUT,
  input wire logic [7:0] AXI_ARADDR_IN,
  // axi read data
  output logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  output logic [31:0] AXI_RDATA_OUT,
  output logic [1:0] AXI_RRESP_OUT,
  // serial clock pin
  input wire logic SCK_IN,
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  // master out pin
  input wire logic MOSI_IN,
  output logic MOSI_OUT,
  output logic MOSI_OE_OUT,
  // master in pin
  input wire logic MISO_IN,
  output logic MISO_OUT,
  output logic MISO_OE_OUT,
  // slave select pin, active low
  input wire logic SS_N_IN,
  // interrupt request
  output logic IRQ_OUT
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [3:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic ss_n_s;

  spi_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk(REF_CLK_IN),
    .rst_n(RST_N_IN),
    .d({SCK_IN, MOSI_IN, MISO_IN, SS_N_IN}),
    .q(pins_s)
  );

  assign sck_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_n_s = pins_s[0];

  // ************************************************************
  // registers and flags
  // ************************************************************
  logic [7:0] control_q;
  logic [2:0] soft_q;
  logic [7:0] rx_buf_q;
  logic done_q;
  logic write_collision_flag_q;
  logic ovr_q;
  logic master_fault_flag_q;
  logic done_acc_q;
  logic done_rd_q;
  logic master_fault_flag_acc_q;
  logic irq_en;
  logic periph_en;
  logic is_master;
  logic output_disable;
  logic select_soft_manage;
  logic select_soft_level;
  logic ss_int_n;

  assign irq_en = control_q[spi_status_pkg::CTL_IRQ_EN_BIT];
  assign periph_en = control_q[spi_status_pkg::CTL_PERIPH_EN_BIT];
  assign is_master = control_q[spi_status_pkg::CTL_MASTER_BIT];
  assign output_disable = soft_q[spi_status_pkg::ST_SOD_BIT];
  assign select_soft_manage = soft_q[spi_status_pkg::ST_SSM_BIT];
  assign select_soft_level = soft_q[spi_status_pkg::ST_SSI_BIT];

  // internal select: software level or pin
  assign ss_int_n = select_soft_manage ? select_soft_level : ss_n_s; // [RQ10] [RQ11]

  // ************************************************************
  // shift engine
  // ************************************************************
  spi_shift_if sif ();

  spi_shift_engine u_engine (
    .clk(REF_CLK_IN),
    .rst_n(RST_N_IN),
    .sif(sif)
  );

  // ************************************************************
  // bus handshake
  // ************************************************************
  logic wr_go;
  logic rd_go;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_ctl;
  logic wr_st;
  logic wr_data;
  logic rd_st;
  logic rd_data;
  logic wr_map;
  logic rd_map;
  logic data_wr_ok;
  logic [7:0] wbyte;

  assign wr_go = AXI_AWVALID_IN && AXI_WVALID_IN && !bvalid_q;
  assign rd_go = AXI_ARVALID_IN && !rvalid_q;
  assign AXI_AWREADY_OUT = wr_go;
  assign AXI_WREADY_OUT = wr_go;
  assign AXI_ARREADY_OUT = rd_go;
  assign wbyte = AXI_WDATA_IN[7:0];

  assign wr_map = (AXI_AWADDR_IN == spi_status_pkg::OFS_CONTROL) ||
    (AXI_AWADDR_IN == spi_status_pkg::OFS_CTL_STATUS) ||
    (AXI_AWADDR_IN == spi_status_pkg::OFS_DATA_IO);
  assign rd_map = (AXI_ARADDR_IN == spi_status_pkg::OFS_CONTROL) ||
    (AXI_ARADDR_IN == spi_status_pkg::OFS_CTL_STATUS) ||
    (AXI_ARADDR_IN == spi_status_pkg::OFS_DATA_IO);

  // low byte lane carries every register
  assign wr_ctl = wr_go && AXI_WSTRB_IN[0] &&
    (AXI_AWADDR_IN == spi_status_pkg::OFS_CONTROL);
  assign wr_st = wr_go && AXI_WSTRB_IN[0] &&
    (AXI_AWADDR_IN == spi_status_pkg::OFS_CTL_STATUS);
  assign wr_data = wr_go && AXI_WSTRB_IN[0] &&
    (AXI_AWADDR_IN == spi_status_pkg::OFS_DATA_IO);
  assign rd_st = rd_go && (AXI_ARADDR_IN == spi_status_pkg::OFS_CTL_STATUS);
  assign rd_data = rd_go && (AXI_ARADDR_IN == spi_status_pkg::OFS_DATA_IO);

  // data write is dropped while done is pending or a byte is moving
  assign data_wr_ok = wr_data && !(done_q && !done_rd_q) && // [RQ3]
    !sif.busy;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      bvalid_q <= 1'b0;
      bresp_q <= spi_status_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_map ? spi_status_pkg::RESP_OKAY :
        spi_status_pkg::RESP_SLVERR;
    end else if (AXI_BREADY_IN) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= spi_status_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_map ? spi_status_pkg::RESP_OKAY :
        spi_status_pkg::RESP_SLVERR;
      case (AXI_ARADDR_IN)
        spi_status_pkg::OFS_CONTROL: begin
          rdata_q <= {24'h000000, control_q};
        end
        spi_status_pkg::OFS_CTL_STATUS: begin
          rdata_q <= {24'h000000, done_q, write_collision_flag_q, ovr_q, master_fault_flag_q, 1'b0,
            soft_q};
        end
        spi_status_pkg::OFS_DATA_IO: begin
          rdata_q <= {24'h000000, rx_buf_q}; // [RQ13]
        end
        default: begin
          rdata_q <= 32'h00000000;
        end
      endcase
    end else if (AXI_RREADY_IN) begin
      rvalid_q <= 1'b0;
    end
  end

  assign AXI_BVALID_OUT = bvalid_q;
  assign AXI_BRESP_OUT = bresp_q;
  assign AXI_RVALID_OUT = rvalid_q;
  assign AXI_RDATA_OUT = rdata_q;
  assign AXI_RRESP_OUT = rresp_q;

  // ************************************************************
  // control and software status bits
  // ************************************************************
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      control_q <= spi_status_pkg::CONTROL_RESET;
    end else if (wr_ctl) begin
      control_q <= wbyte;
    end else if (master_fault_flag_q) begin
      // a fault drops the block out of master mode and off the bus
      control_q[spi_status_pkg::CTL_PERIPH_EN_BIT] <= 1'b0;
      control_q[spi_status_pkg::CTL_MASTER_BIT] <= 1'b0;
    end
  end

  // bit 3 is held at zero whatever is written
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      soft_q <= spi_status_pkg::SOFT_BITS_RESET;
    end else if (wr_st) begin
      soft_q <= wbyte[2:0]; // [RQ15]
    end
  end

  // ************************************************************
  // transfer done and receive buffer
  // ************************************************************
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      rx_buf_q <= spi_status_pkg::RX_BUF_RESET;
    end else if (sif.done && !done_q) begin
      rx_buf_q <= sif.rx_data; // [RQ13]
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      done_q <= 1'b0;
    end else if (sif.done) begin
      done_q <= 1'b1; // [RQ1]
    end else if (done_acc_q && (rd_data || wr_data)) begin
      done_q <= 1'b0; // [RQ2]
    end
  end

  // status access seen while done is set
  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN || !done_q || sif.done) begin
      done_acc_q <= 1'b0;
      done_rd_q <= 1'b0;
    end else begin
      if (rd_st || wr_st) begin
        done_acc_q <= 1'b1; // [RQ2]
      end
      if (rd_st) begin
        done_rd_q <= 1'b1; // [RQ3]
      end
    end
  end

  // ************************************************************
  // collision, overrun and fault flags
  // ************************************************************
  logic write_collision_flag_acc_q;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      write_collision_flag_q <= 1'b0;
      write_collision_flag_acc_q <= 1'b0;
    end else if (wr_data && sif.busy) begin
      write_collision_flag_q <= 1'b1; // [RQ4]
      write_collision_flag_acc_q <= 1'b0;
    end else if (write_collision_flag_q && (rd_st || wr_st)) begin
      write_collision_flag_acc_q <= 1'b1;
    end else if (write_collision_flag_acc_q && (rd_data || wr_data)) begin
      write_collision_flag_q <= 1'b0; // [RQ4]
      write_collision_flag_acc_q <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      ovr_q <= 1'b0;
    end else if (sif.done && done_q) begin
      ovr_q <= 1'b1; // [RQ5]
    end else if (rd_st) begin
      ovr_q <= 1'b0; // [RQ6]
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      master_fault_flag_q <= 1'b0;
    end else if (is_master && periph_en && !ss_int_n) begin
      master_fault_flag_q <= 1'b1; // [RQ7]
    end else if (master_fault_flag_acc_q && wr_ctl) begin
      master_fault_flag_q <= 1'b0; // [RQ8]
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN || !master_fault_flag_q) begin
      master_fault_flag_acc_q <= 1'b0;
    end else if (rd_st || wr_st) begin
      master_fault_flag_acc_q <= 1'b1; // [RQ8]
    end
  end

  // ************************************************************
  // engine hookup
  // ************************************************************
  assign sif.load = data_wr_ok; // [RQ12] [RQ14]
  assign sif.load_data = wbyte;
  assign sif.is_master = is_master;
  assign sif.enabled = periph_en;
  assign sif.selected = !ss_int_n;
  assign sif.sck_s = sck_s;
  assign sif.din_s = is_master ? miso_s : mosi_s;

  // ************************************************************
  // pins and interrupt
  // ************************************************************
  logic master_on;

  assign master_on = periph_en && is_master;
  assign SCK_OUT = sif.sck_out;
  assign SCK_OE_OUT = master_on;
  assign MOSI_OUT = sif.sdo;
  assign MOSI_OE_OUT = master_on && !output_disable; // [RQ9]
  assign MISO_OUT = sif.sdo;
  assign MISO_OE_OUT = periph_en && !is_master && !output_disable && // [RQ9]
    !ss_int_n;

  assign IRQ_OUT = irq_en && (done_q || ovr_q || master_fault_flag_q); // [RQ1] [RQ5] [RQ7] [RQ16]

endmodule

// ==== testbench/spi_far_dev.sv ====
/*
  Far-side serial device model: clock idle low, samples on the rising
  edge, shifts on the falling edge, msb first.
  Assumes the block under test makes the serial clock as master.
*/
module spi_far_dev (
  input wire logic sck,
  input wire logic mosi,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // shift model
  // ************************************************************
  logic [7:0] shift_q;
  logic [7:0] rx_byte;
  initial begin
    shift_q = 8'h00;
    rx_byte = 8'h00;
    miso = 1'h0;
  end
  // byte to send, msb shown before the first rise
  task automatic load(input logic [7:0] b);
    shift_q = b;
    miso = b[7];
  endtask
  // sample on the rising edge, msb first
  always @(posedge sck) rx_byte = {rx_byte[6:0], mosi};
  // shift on the falling edge; spent bits come back inverted
  always @(negedge sck) begin
    shift_q = {shift_q[6:0], ~shift_q[7]};
    miso = shift_q[7];
  end
endmodule

// ==== testbench/spi_status_asserts.sv ====
/*
  Port checker for the serial status and data block.
  Assumes one core clock domain with a synchronous active-low reset.
*/
module spi_status_asserts (
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic AXI_AWVALID_IN,
  input wire logic AXI_AWREADY_OUT,
  input wire logic AXI_WVALID_IN,
  input wire logic AXI_BVALID_OUT,
  input wire logic AXI_BREADY_IN,
  input wire logic [1:0] AXI_BRESP_OUT,
  input wire logic AXI_ARVALID_IN,
  input wire logic AXI_ARREADY_OUT,
  input wire logic AXI_RVALID_OUT,
  input wire logic AXI_RREADY_IN,
  input wire logic [31:0] AXI_RDATA_OUT,
  input wire logic SCK_OUT,
  input wire logic SCK_OE_OUT,
  input wire logic MOSI_OUT,
  input wire logic MOSI_OE_OUT,
  input wire logic MISO_OE_OUT,
  input wire logic IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic aw_hs;
  logic ar_hs;
  assign aw_hs = AXI_AWVALID_IN & AXI_AWREADY_OUT;
  assign ar_hs = AXI_ARVALID_IN & AXI_ARREADY_OUT;
  a_aw_ready: assert property (AXI_AWREADY_OUT ==
    (AXI_AWVALID_IN && AXI_WVALID_IN && !AXI_BVALID_OUT))
    else $error("write ready wrong");
  a_b_follows: assert property (aw_hs |=> AXI_BVALID_OUT)
    else $error("no write response");
  a_b_holds: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
    AXI_BVALID_OUT && $stable(AXI_BRESP_OUT)) else $error("bvalid dropped");
  a_ar_ready: assert property (AXI_ARREADY_OUT ==
    (AXI_ARVALID_IN && !AXI_RVALID_OUT)) else $error("read ready wrong");
  a_r_holds: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
    AXI_RVALID_OUT && $stable(AXI_RDATA_OUT)) else $error("rvalid dropped");
  a_r_upper: assert property (AXI_RVALID_OUT |->
    AXI_RDATA_OUT[31:8] == 24'h0) else $error("upper read bits set");
  a_oe_excl: assert property (
    !(MOSI_OE_OUT && MISO_OE_OUT)) else $error("both outputs driven");
  a_mosi_master: assert property (
    MOSI_OE_OUT |-> SCK_OE_OUT) else $error("mosi driven not master");
  a_sck_high: assert property (
    $rose(SCK_OUT) |-> SCK_OUT[*4]) else $error("serial clock too short");
  a_mosi_hold: assert property (
    SCK_OE_OUT && SCK_OUT && $past(SCK_OUT) |-> $stable(MOSI_OUT))
    else $error("mosi moved while clock high");
  a_irq_fall: assert property (
    $fell(IRQ_OUT) |-> $past(aw_hs) || $past(ar_hs) || $past(aw_hs, 2)
    || $past(ar_hs, 2)) else $error("irq fell without access");
  c_irq: cover property ($rose(IRQ_OUT));
  c_slave: cover property ($rose(MISO_OE_OUT));
  c_slverr: cover property (AXI_BVALID_OUT &&
    AXI_BRESP_OUT == spi_status_pkg::RESP_SLVERR);
endmodule
bind spi_status_data spi_status_asserts chk_i (.*);

// ==== testbench/tb.sv ====
/*
  Self-checking bench for the serial status and data block.
  Assumes the far-side model and the port checker are compiled first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // signals and instances
  // ************************************************************
  logic REF_CLK_IN, RST_N_IN, AXI_AWVALID_IN, AXI_WVALID_IN, SS_N_IN;
  logic AXI_BREADY_IN, AXI_ARVALID_IN, AXI_RREADY_IN, sck_drv, mosi_drv;
  logic [7:0] AXI_AWADDR_IN, AXI_ARADDR_IN, tx, rx, got;
  logic [31:0] AXI_WDATA_IN;
  logic [3:0] AXI_WSTRB_IN;
  wire AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT;
  wire AXI_RVALID_OUT, SCK_OUT, SCK_OE_OUT, MOSI_OUT, MOSI_OE_OUT;
  wire MISO_OUT, MISO_OE_OUT, IRQ_OUT, far_miso, SCK_IN, MOSI_IN, MISO_IN;
  wire [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT;
  wire [31:0] AXI_RDATA_OUT;
  integer seed = 32'h82A605C1;
  int n_errors = 0;
  int cmp_count = 0;
  localparam logic [7:0] CTL = spi_status_pkg::OFS_CONTROL;
  localparam logic [7:0] ST = spi_status_pkg::OFS_CTL_STATUS;
  localparam logic [7:0] DAT = spi_status_pkg::OFS_DATA_IO;
  localparam logic [1:0] ERR = spi_status_pkg::RESP_SLVERR;
  assign SCK_IN = SCK_OE_OUT ? SCK_OUT : sck_drv;
  assign MOSI_IN = MOSI_OE_OUT ? MOSI_OUT : mosi_drv;
  assign MISO_IN = MISO_OE_OUT ? MISO_OUT : far_miso;
  spi_status_data dut (.*);
  spi_far_dev far (.sck(SCK_OUT), .mosi(MOSI_OUT), .miso(far_miso));
  always #10 REF_CLK_IN = ~REF_CLK_IN;
  // ************************************************************
  // tasks
  // ************************************************************
  function automatic logic [7:0] st(input logic d, w, o, m,
                                    input logic [2:0] s);
    return {d, w, o, m, 1'h0, s};
  endfunction
  task automatic chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d,
                    input logic [1:0] r = spi_status_pkg::RESP_OKAY);
    @(posedge REF_CLK_IN);
    AXI_AWVALID_IN <= 1'h1;
    AXI_WVALID_IN <= 1'h1;
    AXI_AWADDR_IN <= a;
    AXI_WDATA_IN <= {24'h0, d};
    AXI_BREADY_IN <= 1'h1;
    do @(posedge REF_CLK_IN); while (AXI_AWREADY_OUT !== 1'h1);
    AXI_AWVALID_IN <= 1'h0;
    AXI_WVALID_IN <= 1'h0;
    do @(posedge REF_CLK_IN); while (AXI_BVALID_OUT !== 1'h1);
    AXI_BREADY_IN <= 1'h0;
    chk(AXI_BRESP_OUT, r);
  endtask
  task automatic rd(input logic [7:0] a, e,
                    input logic [1:0] r = spi_status_pkg::RESP_OKAY);
    @(posedge REF_CLK_IN);
    AXI_ARVALID_IN <= 1'h1;
    AXI_ARADDR_IN <= a;
    AXI_RREADY_IN <= 1'h1;
    do @(posedge REF_CLK_IN); while (AXI_ARREADY_OUT !== 1'h1);
    AXI_ARVALID_IN <= 1'h0;
    do @(posedge REF_CLK_IN); while (AXI_RVALID_OUT !== 1'h1);
    AXI_RREADY_IN <= 1'h0;
    chk(AXI_RDATA_OUT, {24'h0, e});
    chk(AXI_RRESP_OUT, r);
  endtask
  task automatic wait_irq;
    int n = 0;
    while (IRQ_OUT !== 1'h1 && n < 500) begin
      @(posedge REF_CLK_IN);
      n++;
    end
    chk(IRQ_OUT, 1'h1);
  endtask
  // one byte from a far master, 160 ns clock, msb first
  task automatic frame(input logic [7:0] b);
    #7;
    for (int i = 7; i >= 0; i--) begin
      mosi_drv <= b[i];
      #80 sck_drv <= 1'h1;
      got = {got[6:0], MISO_IN};
      #80 sck_drv <= 1'h0;
    end
    mosi_drv <= ~b[0];
    repeat (12) @(posedge REF_CLK_IN);
  endtask
  task automatic end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_errors++;
    end_sim;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {REF_CLK_IN, RST_N_IN, AXI_AWVALID_IN, AXI_WVALID_IN} = 4'h0;
    {AXI_BREADY_IN, AXI_ARVALID_IN, AXI_RREADY_IN, sck_drv} = 4'h0;
    {AXI_AWADDR_IN, AXI_ARADDR_IN, AXI_WDATA_IN} = 48'h0;
    AXI_WSTRB_IN = 4'hF;
    SS_N_IN = 1'h1;
    mosi_drv = 1'h0;
    repeat (5) @(posedge REF_CLK_IN);
    RST_N_IN <= 1'h1;
    rd(CTL, 8'h00);
    rd(ST, st(0, 0, 0, 0, 3'h0));
    rd(8'h0C, 8'h00, ERR);
    wr(8'h10, 8'h5A, ERR);
    wr(ST, 8'h07);
    rd(ST, st(0, 0, 0, 0, 3'h7));
    wr(ST, 8'h00);
    wr(CTL, 8'hD0);
    chk(MOSI_OE_OUT, 1'h1);
    for (int k = 0; k < 4; k++) begin
      tx = (k == 0) ? 8'hFF : 8'($random(seed));
      rx = (k == 1) ? 8'h00 : 8'($random(seed));
      far.load(rx);
      wr(DAT, tx);
      wait_irq;
      chk(far.rx_byte, tx);
      wr(DAT, ~tx);
      repeat (90) @(posedge REF_CLK_IN);
      chk(far.rx_byte, tx);
      rd(ST, st(1, 0, 0, 0, 3'h0));
      rd(DAT, rx);
      chk(IRQ_OUT, 1'h0);
    end
    far.load(8'h3C);
    tx = 8'($random(seed));
    wr(DAT, tx);
    wr(DAT, ~tx);
    wait_irq;
    rd(ST, st(1, 1, 0, 0, 3'h0));
    rd(DAT, 8'h3C);
    rd(ST, st(0, 0, 0, 0, 3'h0));
    chk(far.rx_byte, tx);
    SS_N_IN <= 1'h0;
    repeat (8) @(posedge REF_CLK_IN);
    chk(IRQ_OUT, 1'h1);
    rd(ST, st(0, 0, 0, 1, 3'h0));
    rd(CTL, 8'h80);
    SS_N_IN <= 1'h1;
    wr(CTL, 8'hD0);
    rd(ST, st(0, 0, 0, 0, 3'h0));
    wr(ST, 8'h04);
    chk(MOSI_OE_OUT, 1'h0);
    wr(CTL, 8'hC0);
    wr(ST, 8'h02);
    chk(MISO_OE_OUT, 1'h1);
    wr(ST, 8'h06);
    chk(MISO_OE_OUT, 1'h0);
    wr(ST, 8'h02);
    tx = 8'($random(seed));
    rx = 8'($random(seed));
    wr(DAT, rx);
    frame(tx);
    chk(got, rx);
    wait_irq;
    frame(rx);
    rd(ST, st(1, 0, 1, 0, 3'h2));
    rd(ST, st(1, 0, 0, 0, 3'h2));
    rd(DAT, tx);
    wr(ST, 8'h03);
    frame(rx);
    rd(ST, st(0, 0, 0, 0, 3'h3));
    wr(ST, 8'h00);
    frame(rx);
    rd(ST, st(0, 0, 0, 0, 3'h0));
    SS_N_IN <= 1'h0;
    frame(rx);
    wait_irq;
    rd(ST, st(1, 0, 0, 0, 3'h0));
    rd(DAT, rx);
    end_sim;
  end
endmodule
